// ### rtl/phy_autoneg_control.sv
/*
 * Auto-negotiation control for one Ethernet port: strap capture, register
 * file on a classic Wishbone slave, negotiation sequencing, priority
 * resolution, parallel detection and LED polarity.
 * Assumes the link pulse and page engines sit outside and deliver received
 * pages and the partner ability indication synchronous to the core clock; the
 * straps and link levels come from pins and are synchronised here.
 */
// Decided for this implementation: the Wishbone slave port.
// Functional notes
// - Strap enable low forces mode from two ability straps.
// - Strap enable high chooses advertised abilities from the ability straps.
// - Advertisement bits 8 to 5 load from straps at each reset with strap enable high.
// - Software may override strap behaviour by writing basic control.
// - While negotiating, advertise the advertisement register abilities.
// - Resolve 100 full, 100 half, 10 full, 10 half in that order.
// - Negotiation off: speed and duplex come from control bits.
// - Negotiation on: speed and duplex control bits are ignored.
// - Link status register reports resolved speed once link is up.
// - Basic status ability bits are constant; 100BASE-T4 reads zero.
// - Basic status shows done, remote fault, link, preamble suppression.
// - Reset advertises all abilities; cleared bits stop being advertised.
// - Partner register captures pages; parallel detect gives 0081 or 0021.
// - Expansion shows detect fault, next-page abilities, page, partner able.
// - Both receivers report link; configure the one seeing valid link.
// - Parallel detect sets partner bit 5 or 7 and selector 00001.
// - Parallel detect shows partner able zero with negotiation done.
// - Parallel detect fault set unless exactly one good link; code sets it only in the parallel detect state, which needs a link to enter.
// - Restart bit or link loss restarts negotiation.
// - Renegotiation silences transmit until the 1500 ms timer ends.
// - Negotiation or parallel detection finishes within about three seconds.
// - LED output active high if strap low, active low if strap high.
`timescale 1ns/10ps
`include "phy_autoneg_regs.svh"

module phy_autoneg_control #(
	parameter int BREAK_CYCLES = `BREAK_LINK_CYCLES,
	parameter int TIMEOUT_CYCLES = `NEG_TIMEOUT_CYCLES
) (
	input wire logic clock, // Core clock, 100 MHz.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic negotiate_strap_enable, // Strap pin.
	input wire logic ability_strap_low, // Strap pin.
	input wire logic ability_strap_high, // Strap pin.
	input wire logic link10Good, // 10 Mb/s receiver link, async.
	input wire logic link100Good, // 100 Mb/s receiver link, async.
	input wire logic pageValid, // One-cycle pulse, received page.
	input wire logic [15:0] pageWord, // Received code word.
	input wire logic partnerNegAble, // Partner sends link pulse bursts.
	input wire logic [31:0] wb_adr_i, // Wishbone byte address.
	input wire logic [31:0] wb_dat_i, // Wishbone write data.
	input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
	input wire logic wb_we_i, // Wishbone write enable.
	input wire logic wb_cyc_i, // Wishbone cycle.
	input wire logic wb_stb_i, // Wishbone strobe.
	output logic [31:0] wb_dat_o, // Wishbone read data.
	output logic wb_ack_o, // Wishbone acknowledge.
	output logic txSilent, // Transmit data and pulses halted.
	output logic sendBursts, // Send advertisement in bursts.
	output logic [15:0] advertWord, // Word to send in bursts.
	output logic linkSpeed100, // Operating speed is 100 Mb/s.
	output logic linkFullDuplex, // Operating duplex is full.
	output logic ledLink, // Link LED pin level.
	output logic ledSpeed // Speed LED pin level.
);

	// ------------------------------------------------------------------
	// Synchronisers and strap capture.
	// ------------------------------------------------------------------
	logic [4:0] syncA_r, syncB_r;
	logic strapDone_r, strapEn_r, strapLo_r, strapHi_r;

	// Pins pass two flops; only the second stage is read.
	always_ff @(posedge clock) begin
		syncA_r <= {negotiate_strap_enable, ability_strap_low,
			ability_strap_high, link10Good, link100Good};
		syncB_r <= syncA_r;
	end

	wire logic l10 = syncB_r[1];
	wire logic l100 = syncB_r[0];

	// Capture after release, so a reset flop never loads a pin.
	always_ff @(posedge clock) begin
		if (rst) begin
			strapDone_r <= 1'b0;
			strapEn_r <= 1'b0;
			strapLo_r <= 1'b0;
			strapHi_r <= 1'b0;
		end else if (!strapDone_r) begin
			strapDone_r <= 1'b1;
			strapEn_r <= syncB_r[4];
			strapLo_r <= syncB_r[3];
			strapHi_r <= syncB_r[2];
		end
	end

	// ------------------------------------------------------------------
	// Registers.
	// ------------------------------------------------------------------
	logic speed_r, duplex_r, restartReq_r;
	logic [15:0] advert_r, partner_r;
	logic pdFault_r, pageRx_r, negDone_r, viaPd_r;
	logic opSpeed_r, opDuplex_r, linkUp_r;
	phy_autoneg_pkg::neg_state_t state_r;
	logic [31:0] timer_r;

	wire logic [4:0] regIdx = wb_adr_i[6:2];
	wire logic busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire logic wrLo = busReq && wb_we_i && wb_sel_i[0];
	wire logic wrHi = busReq && wb_we_i && wb_sel_i[1];
	wire logic wrCtl = regIdx == `IDX_BASIC_CONTROL;
	wire logic wrAdv = regIdx == `IDX_ADVERT;
	wire logic wrForce = wrCtl && wrHi && !wb_dat_i[`BC_NEG_EN];

	// Strap-derived advertisement bits 8..5.
	logic [3:0] strapAdv;
	always_comb begin
		case ({strapHi_r, strapLo_r})
			2'h0: strapAdv = 4'h3;
			2'h1: strapAdv = 4'hC;
			2'h2: strapAdv = 4'h5;
			default: strapAdv = 4'hF;
		endcase
	end

	// Basic control speed and duplex: cleared at reset, then software owns them.
	always_ff @(posedge clock) begin
		if (rst) begin
			speed_r <= 1'b0;
			duplex_r <= 1'b0;
			restartReq_r <= 1'b0;
		end else if (strapDone_r) begin
			restartReq_r <= 1'b0;
			if (wrCtl && wrHi) begin
				speed_r <= wb_dat_i[`BC_SPEED];
				restartReq_r <= wb_dat_i[`BC_RESTART];
				duplex_r <= wb_dat_i[`BC_DUPLEX];
			end
		end
	end

	// Forced straps are applied the cycle after capture.
	logic strapApplied_r;
	always_ff @(posedge clock) begin
		if (rst) begin
			strapApplied_r <= 1'b0;
		end else if (strapDone_r) begin
			strapApplied_r <= 1'b1;
		end
	end

	// Negotiation enable as seen by the sequencer.
	logic negEnEff_r;
	always_ff @(posedge clock) begin
		if (rst) begin
			negEnEff_r <= 1'b0;
		end else if (strapDone_r && !strapApplied_r) begin
			negEnEff_r <= strapEn_r;
		end else if (wrCtl && wrHi) begin
			negEnEff_r <= wb_dat_i[`BC_NEG_EN];
		end
	end

	// Advertisement: all abilities after reset, strap bits once captured with strap enable high.
	always_ff @(posedge clock) begin
		if (rst) begin
			advert_r <= {7'h00, 4'hF, `SELECTOR_8023};
		end else if (strapDone_r && !strapApplied_r && strapEn_r) begin
			advert_r[`AD_100F:`AD_10H] <= strapAdv;
		end else begin
			if (wrLo && wrAdv) begin
				advert_r[7:0] <= wb_dat_i[7:0];
			end
			if (wrHi && wrAdv) begin
				advert_r[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	// ------------------------------------------------------------------
	// Negotiation sequencer.
	// ------------------------------------------------------------------
	// Link of the technology in use, read directly so that a fresh
	// resolution is not taken for a link loss one cycle later.
	wire logic opLink = opSpeed_r ? l100 : l10;
	wire logic anyLink = l10 || l100;
	wire logic twoOrNone = l10 == l100;

	always_ff @(posedge clock) begin
		if (rst) begin
			state_r <= phy_autoneg_pkg::ST_FORCED;
			timer_r <= 32'h0000_0000;
			partner_r <= 16'h0000;
			pdFault_r <= 1'b0;
			pageRx_r <= 1'b0;
			negDone_r <= 1'b0;
			viaPd_r <= 1'b0;
			opSpeed_r <= 1'b0;
			opDuplex_r <= 1'b0;
		end else if (strapDone_r && !strapApplied_r && !strapEn_r) begin
			opSpeed_r <= strapHi_r;
			opDuplex_r <= strapLo_r;
		end else if (!negEnEff_r || wrForce) begin
			state_r <= phy_autoneg_pkg::ST_FORCED;
			negDone_r <= 1'b0;
			if (wrForce) begin
				opSpeed_r <= wb_dat_i[`BC_SPEED];
				opDuplex_r <= wb_dat_i[`BC_DUPLEX];
			end
		end else if (restartReq_r || state_r == phy_autoneg_pkg::ST_FORCED
			|| (state_r == phy_autoneg_pkg::ST_DONE && !opLink)) begin
			// Enable rising, restart or link loss all go via the break.
			state_r <= phy_autoneg_pkg::ST_BREAK;
			timer_r <= 32'h0000_0000;
			negDone_r <= 1'b0;
			viaPd_r <= 1'b0;
		end else begin
			if (pageRx_r && wb_ack_o && !wb_we_i
				&& regIdx == `IDX_EXPANSION) begin
				pageRx_r <= 1'b0;
			end
			case (state_r)
				phy_autoneg_pkg::ST_BREAK: begin
					timer_r <= timer_r + 32'h0000_0001;
					if (timer_r >= BREAK_CYCLES - 1) begin
						state_r <= phy_autoneg_pkg::ST_ABILITY;
						timer_r <= 32'h0000_0000;
						pdFault_r <= 1'b0;
					end
				end
				phy_autoneg_pkg::ST_ABILITY: begin
					timer_r <= timer_r + 32'h0000_0001;
					if (pageValid) begin
						partner_r <= pageWord;
						pageRx_r <= 1'b1; // Set wins over read clear.
					end
					if (pageValid && partnerNegAble) begin
						state_r <= phy_autoneg_pkg::ST_DONE;
						negDone_r <= 1'b1;
						opSpeed_r <= pageWord[`AD_100F] & advert_r[`AD_100F]
							|| pageWord[`AD_100H] & advert_r[`AD_100H];
						opDuplex_r <= pageWord[`AD_100F] & advert_r[`AD_100F]
							|| !(pageWord[`AD_100H] & advert_r[`AD_100H])
							&& pageWord[`AD_10F] & advert_r[`AD_10F];
					end else if (!partnerNegAble && anyLink) begin
						state_r <= phy_autoneg_pkg::ST_PDETECT;
					end else if (timer_r >= TIMEOUT_CYCLES - 1) begin
						state_r <= phy_autoneg_pkg::ST_BREAK;
						timer_r <= 32'h0000_0000;
					end
				end
				phy_autoneg_pkg::ST_PDETECT: begin
					if (twoOrNone) begin
						pdFault_r <= 1'b1;
						state_r <= phy_autoneg_pkg::ST_ABILITY;
					end else begin
						state_r <= phy_autoneg_pkg::ST_DONE;
						negDone_r <= 1'b1;
						viaPd_r <= 1'b1;
						opSpeed_r <= l100;
						opDuplex_r <= 1'b0;
						partner_r <= l100 ? `PD_PARTNER_100
							: `PD_PARTNER_10;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Resolved link valid in the operating technology.
	always_ff @(posedge clock) begin
		if (rst) begin
			linkUp_r <= 1'b0;
		end else begin
			linkUp_r <= opLink;
		end
	end

	// ------------------------------------------------------------------
	// Transmit control and pins.
	// ------------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			txSilent <= 1'b0;
			sendBursts <= 1'b0;
			advertWord <= 16'h0000;
			linkSpeed100 <= 1'b0;
			linkFullDuplex <= 1'b0;
			ledLink <= 1'b0;
			ledSpeed <= 1'b0;
		end else begin
			txSilent <= state_r == phy_autoneg_pkg::ST_BREAK;
			sendBursts <= state_r == phy_autoneg_pkg::ST_ABILITY;
			advertWord <= advert_r;
			linkSpeed100 <= opSpeed_r;
			linkFullDuplex <= opDuplex_r;
			ledLink <= linkUp_r ^ strapLo_r;
			ledSpeed <= opSpeed_r ^ strapHi_r;
		end
	end

	// ------------------------------------------------------------------
	// Wishbone read path; ack one cycle after the strobe, then low.
	// ------------------------------------------------------------------
	logic [15:0] rdData;
	always_comb begin
		if (regIdx == `IDX_BASIC_CONTROL) begin
			rdData = 16'h0000;
			rdData[`BC_SPEED] = speed_r;
			rdData[`BC_NEG_EN] = negEnEff_r;
			rdData[`BC_DUPLEX] = duplex_r;
		end else if (regIdx == `IDX_BASIC_STATUS) begin
			rdData = `BASIC_STATUS_FIXED;
			rdData[`BS_NEG_DONE] = negDone_r;
			rdData[`BS_REMOTE_FAULT] = partner_r[`PA_REMOTE_FAULT]
				&& !viaPd_r;
			rdData[`BS_LINK] = linkUp_r;
		end else if (regIdx == `IDX_ADVERT) begin
			rdData = advert_r;
		end else if (regIdx == `IDX_PARTNER) begin
			rdData = partner_r;
		end else if (regIdx == `IDX_EXPANSION) begin
			rdData = {11'h000, pdFault_r,
				partner_r[`PA_NEXT_PAGE] && !viaPd_r,
				1'b0, pageRx_r, negDone_r && !viaPd_r};
		end else if (regIdx == `IDX_LINK_STATUS) begin
			rdData = {13'h0000, opDuplex_r, !opSpeed_r, linkUp_r};
		end else begin
			rdData = 16'h0000;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= busReq;
			wb_dat_o <= busReq ? {16'h0000, rdData} : 32'h0000_0000;
		end
	end

endmodule

// ### common/phy_autoneg_regs.svh
/*
 * Register offsets, field positions, reset values and timing constants for
 * the auto-negotiation control block.
 * Assumes a Wishbone slave with 32-bit data and word-aligned registers.
 */
`ifndef PHY_AUTONEG_REGS_SVH
`define PHY_AUTONEG_REGS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index).
// ----------------------------------------------------------------------
`define IDX_BASIC_CONTROL 5'h00
`define IDX_BASIC_STATUS 5'h01
`define IDX_ADVERT 5'h04
`define IDX_PARTNER 5'h05
`define IDX_EXPANSION 5'h06
`define IDX_LINK_STATUS 5'h10

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define BC_SPEED 13
`define BC_NEG_EN 12
`define BC_RESTART 9
`define BC_DUPLEX 8
`define AD_10H 5
`define AD_10F 6
`define AD_100H 7
`define AD_100F 8

// ----------------------------------------------------------------------
// Fixed values.
// ----------------------------------------------------------------------
`define SELECTOR_8023 5'h01
`define PA_REMOTE_FAULT 13
`define PA_NEXT_PAGE 15
`define PD_PARTNER_100 16'h0081
`define PD_PARTNER_10 16'h0021
// Abilities 100FD,100HD,10FD,10HD, preamble suppression, extended regs.
`define BASIC_STATUS_FIXED 16'h7849
`define BS_NEG_DONE 5
`define BS_REMOTE_FAULT 4
`define BS_NEG_ABLE 3
`define BS_LINK 2

// ----------------------------------------------------------------------
// Timing.
// ----------------------------------------------------------------------
`define CLOCK_MHZ 100
`define BREAK_LINK_MS 1500
`define BREAK_LINK_CYCLES (`BREAK_LINK_MS * 1000 * `CLOCK_MHZ)
`define NEG_TIMEOUT_MS 3000
`define NEG_TIMEOUT_CYCLES (`NEG_TIMEOUT_MS * 1000 * `CLOCK_MHZ)

`endif

// ### common/phy_autoneg_pkg.sv
/*
 * Types for the auto-negotiation control block.
 * Assumes the constants header is included by the design file.
 */
package phy_autoneg_pkg;

	// ------------------------------------------------------------------
	// Negotiation state machine.
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_FORCED,
		ST_BREAK,
		ST_ABILITY,
		ST_DONE,
		ST_PDETECT
	} neg_state_t;

endpackage

// ### verification/phy_autoneg_control_asserts.sv
/* Port checker for phy_autoneg_control.
   Bound to every instance of the block; sees its ports only. */
`timescale 1ns/10ps

module phy_autoneg_control_asserts #(
	parameter int BREAK_CYCLES = 20
) (
	input wire logic clock, // Core clock.
	input wire logic rst, // Sync reset.
	input wire logic partnerNegAble, // Partner negotiates.
	input wire logic link10Good, // 10 Mb/s link.
	input wire logic link100Good, // 100 Mb/s link.
	input wire logic pageValid, // Page pulse.
	input wire logic wb_cyc_i, // Bus cycle.
	input wire logic wb_stb_i, // Bus strobe.
	input wire logic wb_ack_o, // Bus acknowledge.
	input wire logic [31:0] wb_dat_o, // Read data.
	input wire logic txSilent, // Break timer running.
	input wire logic sendBursts // Bursts sent.
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// -------------------------------------------------------------
	// Break length counter.
	// -------------------------------------------------------------
	int silentCnt_r;

	// A counter rather than a repetition, so real break counts stay cheap.
	always_ff @(posedge clock) begin
		if (rst || !txSilent)
			silentCnt_r <= 0;
		else
			silentCnt_r <= silentCnt_r + 1;
	end

	AST_ACK_LATENCY: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	AST_ACK_SINGLE: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	AST_ACK_CAUSE: assert property (
		$rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack uncalled");
	AST_DATA_UPPER: assert property (
		wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper data set");
	AST_QUIET_BREAK: assert property (
		txSilent |-> !sendBursts)
		else $error("bursts in break");
	AST_BREAK_LEN: assert property (
		$fell(txSilent) |-> silentCnt_r inside
		{[BREAK_CYCLES - 1:BREAK_CYCLES + 1]})
		else $error("break length");
	AST_BURST_RESUME: assert property (
		$fell(txSilent) |-> ##[0:1] sendBursts)
		else $error("no bursts after break");
	AST_PAGE_DONE: assert property (
		sendBursts && pageValid && partnerNegAble |-> ##[1:3] !sendBursts)
		else $error("page ignored");
	// Two sync stages, two state steps (ability to detect, detect to done) and the output flop fit in six.
	AST_PD_DONE: assert property (
		sendBursts && !partnerNegAble && link10Good != link100Good
		|-> ##[1:6] !sendBursts)
		else $error("parallel detect stuck");
endmodule

bind phy_autoneg_control phy_autoneg_control_asserts #(
	.BREAK_CYCLES(BREAK_CYCLES)
) chk (
	.clock(clock),
	.rst(rst),
	.partnerNegAble(partnerNegAble),
	.link10Good(link10Good),
	.link100Good(link100Good),
	.pageValid(pageValid),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o),
	.wb_dat_o(wb_dat_o),
	.txSilent(txSilent),
	.sendBursts(sendBursts)
);

// ### verification/link_partner_model.sv
/* Behavioural link partner across the cable.
   Assumes the bench sets its behaviour through the plain inputs. */
`timescale 1ns/10ps

module link_partner_model (
	input wire logic clock, // Core clock.
	input wire logic rst, // Sync reset.
	input wire logic sendBursts, // Local bursts on the cable.
	input wire logic negAble, // Partner runs negotiation.
	input wire logic lnk10, // Partner sends 10 Mb/s link.
	input wire logic lnk100, // Partner sends 100 Mb/s link.
	input wire logic [7:0] dly, // Burst cycles before the page.
	input wire logic [15:0] abil, // Partner base page.
	output logic link10Good, // 10 Mb/s receiver link.
	output logic link100Good, // 100 Mb/s receiver link.
	output logic partnerNegAble, // Partner bursts seen.
	output logic pageValid, // Page received pulse.
	output logic [15:0] pageWord // Page code word.
);
	logic [7:0] cnt_r;

	// One page per burst phase; the partner answers only bursts.
	always_ff @(posedge clock) begin
		if (rst || !sendBursts || !negAble) begin
			cnt_r <= 8'h00;
			pageValid <= 1'b0;
		end else begin
			if (cnt_r <= dly)
				cnt_r <= cnt_r + 8'h01;
			pageValid <= (cnt_r == dly);
		end
	end

	// Outside a page the word is inverted so stale data never matches.
	assign pageWord = pageValid ? abil : ~abil;
	assign link10Good = lnk10;
	assign link100Good = lnk100;
	assign partnerNegAble = negAble;
endmodule

// ### verification/phy_autoneg_control_tb_top.sv
/* Self-checking bench for phy_autoneg_control with a partner model.
   Assumes the break count is shortened to 20 and the timeout to 200. */
`timescale 1ns/10ps

module phy_autoneg_control_tb_top;
	logic clock, rst, sEn, sLo, sHi, negAble, l10, l100, we, cyc, stb, ack;
	logic link10Good, link100Good, pageValid, partnerNegAble, txSilent;
	logic sendBursts, spd, fdx, ledLink, ledSpeed;
	logic [15:0] pageWord, abil, q, advertWord;
	logic [31:0] adr, datI, datO;
	logic [7:0] dly;
	int n_fail, cmp_count;

	phy_autoneg_control #(.BREAK_CYCLES(20), .TIMEOUT_CYCLES(200))
	u_phy_autoneg_control (.clock(clock), .rst(rst),
		.negotiate_strap_enable(sEn), .ability_strap_low(sLo),
		.ability_strap_high(sHi), .link10Good(link10Good),
		.link100Good(link100Good), .pageValid(pageValid),
		.pageWord(pageWord), .partnerNegAble(partnerNegAble),
		.wb_adr_i(adr), .wb_dat_i(datI), .wb_sel_i(4'h3), .wb_we_i(we),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(datO), .wb_ack_o(ack),
		.txSilent(txSilent), .sendBursts(sendBursts),
		.advertWord(advertWord), .linkSpeed100(spd), .linkFullDuplex(fdx),
		.ledLink(ledLink), .ledSpeed(ledSpeed));

	link_partner_model partner (.clock(clock), .rst(rst),
		.sendBursts(sendBursts), .negAble(negAble), .lnk10(l10),
		.lnk100(l100), .dly(dly), .abil(abil), .link10Good(link10Good),
		.link100Good(link100Good), .partnerNegAble(partnerNegAble),
		.pageValid(pageValid), .pageWord(pageWord));

	// -------------------------------------------------------------
	// Clock and checking helpers.
	// -------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic chkBit(input string nm, input logic e, s);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s expected %b seen %b", nm, e, s);
		end
	endtask

	task automatic chkVal(input string nm, input logic [15:0] e, s);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask

	task report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// One classic cycle; the answer is read at the edge it is seen.
	task automatic wb(input logic [31:0] a, input logic w,
		input logic [15:0] d, output logic [15:0] r);
		int n;
		adr <= a;
		we <= w;
		datI <= {16'h0000, d};
		cyc <= 1'b1;
		stb <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (ack !== 1'b1);
		r = datO[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		// Only the watchdog ends the wait; the latency is judged after.
		chkVal("ackEdges", 16'h0002, n[15:0]);
		@(posedge clock);
	endtask

	task automatic waitLvl(ref logic s, input logic v, input int m);
		int n;
		n = 0;
		while (s !== v && n < m) begin
			@(posedge clock);
			n++;
		end
		chkBit("wait", v, s);
	endtask

	task automatic doReset(input logic e, h, l);
		sEn <= e;
		sHi <= h;
		sLo <= l;
		rst <= 1'b1;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		repeat (8) @(posedge clock);
	endtask

	// -------------------------------------------------------------
	// Scenarios.
	// -------------------------------------------------------------
	task automatic testStraps;
		logic [3:0] ad [4] = '{4'h3, 4'hC, 4'h5, 4'hF};
		for (int i = 0; i < 8; i++) begin
			doReset(i[2], i[1], i[0]);
			if (!i[2]) begin
				chkBit("speed", i[1], spd);
				chkBit("duplex", i[0], fdx);
				chkBit("ledSpeed", 1'b0, ledSpeed);
				chkBit("ledLink", i[0], ledLink);
			end else begin
				wb(32'h10, 1'b0, 16'h0000, q);
				chkVal("advert", {12'h000, ad[i[1:0]]}, {12'h000, q[8:5]});
			end
		end
	endtask

	task automatic testForced;
		doReset(1'b0, 1'b1, 1'b1);
		sHi <= 1'b0;
		sLo <= 1'b0;
		repeat (6) @(posedge clock);
		chkBit("speed", 1'b1, spd);
		wb(32'h0, 1'b1, 16'h0100, q);
		chkBit("speed", 1'b0, spd);
		chkBit("duplex", 1'b1, fdx);
		chkBit("bursts", 1'b0, sendBursts);
		wb(32'h0, 1'b1, 16'h1200, q);
		waitLvl(txSilent, 1'b1, 5);
		wb(32'h0, 1'b0, 16'h0000, q);
		chkBit("restart", 1'b0, q[9]);
	endtask

	task automatic testRegs;
		wb(32'h4, 1'b0, 16'h0000, q);
		chkVal("status", 16'h7849, q & 16'hFFCB);
		wb(32'h7C, 1'b1, 16'hFFFF, q);
		wb(32'h7C, 1'b0, 16'h0000, q);
		chkVal("unmapped", 16'h0000, q);
		wb(32'h10, 1'b1, 16'h0021, q);
		wb(32'h10, 1'b0, 16'h0000, q);
		chkVal("advert", 16'h0021, q);
		chkVal("advertWord", 16'h0021, advertWord);
		wb(32'h10, 1'b1, 16'h01E1, q);
	endtask

	task automatic testNeg(input logic [15:0] pa, input logic e100, efd);
		abil <= pa;
		l10 <= !e100;
		l100 <= e100;
		negAble <= 1'b1;
		dly <= efd ? 8'h0C : 8'h01;
		wb(32'h0, 1'b1, 16'h1200, q);
		waitLvl(txSilent, 1'b1, 5);
		waitLvl(txSilent, 1'b0, 40);
		waitLvl(sendBursts, 1'b1, 5);
		waitLvl(sendBursts, 1'b0, 60);
		repeat (4) @(posedge clock);
		chkBit("speed", e100, spd);
		chkBit("duplex", efd, fdx);
		wb(32'h14, 1'b0, 16'h0000, q);
		chkVal("partner", pa, q);
		wb(32'h40, 1'b0, 16'h0000, q);
		chkVal("linkStatus", {13'h0000, efd, !e100, 1'b1}, q);
		wb(32'h4, 1'b0, 16'h0000, q);
		chkBit("done", 1'b1, q[5]);
		wb(32'h18, 1'b0, 16'h0000, q);
		chkBit("pageRx", 1'b1, q[1]);
		wb(32'h18, 1'b0, 16'h0000, q);
		chkBit("pageRx", 1'b0, q[1]);
	endtask

	task automatic testPd(input logic a, b, input logic [15:0] pa);
		negAble <= 1'b0;
		l10 <= a;
		l100 <= b;
		wb(32'h0, 1'b1, 16'h1200, q);
		waitLvl(txSilent, 1'b1, 5);
		waitLvl(txSilent, 1'b0, 40);
		repeat (12) @(posedge clock);
		wb(32'h18, 1'b0, 16'h0000, q);
		if (a == b) begin
			chkBit("pdFault", 1'b1, q[4]);
		end else begin
			chkBit("partnerAble", 1'b0, q[0]);
			chkBit("speed", b, spd);
			wb(32'h14, 1'b0, 16'h0000, q);
			chkVal("partner", pa, q);
			wb(32'h4, 1'b0, 16'h0000, q);
			chkBit("done", 1'b1, q[5]);
		end
	endtask

	// Twenty thousand cycles is about forty times the expected run.
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		report_and_stop;
	end

	initial begin
		{negAble, l10, l100, we, cyc, stb} = 6'h00;
		adr = 32'h0;
		datI = 32'h0;
		abil = 16'h0;
		dly = 8'h01;
		n_fail = 0;
		cmp_count = 0;
		testStraps;
		testForced;
		testRegs;
		testNeg(16'h01E1, 1'b1, 1'b1);
		testNeg(16'h00A1, 1'b1, 1'b0);
		testNeg(16'h0061, 1'b0, 1'b1);
		testNeg(16'h0021, 1'b0, 1'b0);
		testPd(1'b1, 1'b1, 16'h0000);
		testPd(1'b0, 1'b1, 16'h0081);
		l100 <= 1'b0;
		waitLvl(txSilent, 1'b1, 10);
		// Let the loss break run out so the restart starts a fresh one.
		waitLvl(txSilent, 1'b0, 40);
		testPd(1'b1, 1'b0, 16'h0021);
		report_and_stop;
	end
endmodule
